/* hdl/fnas_node_address_select.v */
`timescale 1ns/1ns
`include "fnas_regs.vh"

// What this block does
// - seven switches, weights 1 to 64, form a 7-bit switch address.
// - switch address 0 selects the software node address setting.
// - only addresses 1 to 125 are usable station addresses.
// - switch values 126 and 127 are invalid and never adopted.
// - setting accepts 1 to 125 and holds 3 after reset.
// - writes to the setting are ignored while switches give a valid address.
// - setting reads back the switch address while switches give a valid address.
// - switches are sampled only once after each reset, later changes ignored.
module fnas_node_address_select
(
   input  wire       i_clk,
   input  wire       i_reset,
   input  wire [6:0] i_switch,
   input  wire       i_setting_wr,
   input  wire [6:0] i_setting_wdata,
   output reg  [6:0] o_setting_rdata,
   output reg  [6:0] o_station_addr,
   output reg        o_addr_valid,
   output reg        o_switch_locked,
   output reg        o_switch_invalid,
   output reg        o_ready
);

   localparam ST_SAMPLE = 2'b01;
   localparam ST_RUN    = 2'b10;

   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg  [6:0] switch_addr_r;
   reg  [6:0] switch_addr_nxt;
   reg  [6:0] setting_r;
   reg  [6:0] setting_nxt;
   reg  [6:0] station_nxt;
   reg        valid_nxt;
   reg  [6:0] rdata_nxt;
   reg        invalid_nxt;

   wire [6:0] weight_sum [0:7];
   wire [6:0] switch_word;
   wire       sampling;
   wire       running;
   wire       sw_valid;
   wire       wr_valid;
   wire       sw_zero;
   wire       locked;
   wire       wr_accept;

   genvar     g;

   // closed switches add their binary weights; weights never overlap, so or-ing sums them
   assign weight_sum[0] = 7'h00;

   generate
      for (g = 0; g < `FNAS_ADDR_W; g = g + 1)
      begin : g_weight
         assign weight_sum[g + 1] = weight_sum[g] | (i_switch[g] ? (7'h01 << g) : 7'h00);
      end
   endgenerate

   assign switch_word = weight_sum[`FNAS_ADDR_W];

   // one range check for the sampled switches, one for incoming writes
   fnas_range_check u_sw_chk
   (
      .i_addr  (switch_addr_r),
      .o_valid (sw_valid)
   );

   fnas_range_check u_wr_chk
   (
      .i_addr  (i_setting_wdata),
      .o_valid (wr_valid)
   );

   assign sampling  = (state_r == ST_SAMPLE);
   assign running   = (state_r == ST_RUN);
   assign sw_zero   = (switch_addr_r == `FNAS_ADDR_SW_SEL);
   // a usable switch address locks the setting against writes
   assign locked    = sw_valid;
   assign wr_accept = running && i_setting_wr && !locked && wr_valid;

   // one pass through sampling per reset, then run until the next reset
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_SAMPLE: state_nxt = ST_RUN;
         ST_RUN:    state_nxt = ST_RUN;
         default:   state_nxt = ST_SAMPLE;
      endcase
   end

   // switches are taken once, in the first cycle after reset; later moves are ignored
   always @*
   begin
      switch_addr_nxt = switch_addr_r;
      if (sampling)
      begin
         switch_addr_nxt = switch_word;
      end
   end

   always @*
   begin
      setting_nxt = setting_r;
      if (wr_accept)
      begin
         setting_nxt = i_setting_wdata;
      end
   end

   always @*
   begin
      station_nxt = 7'h00;
      valid_nxt   = 1'b0;
      if (locked)
      begin
         station_nxt = switch_addr_r;
         valid_nxt   = 1'b1;
      end
      else if (sw_zero)
      begin
         station_nxt = setting_nxt;
         valid_nxt   = 1'b1;
      end
      // 126 and 127 leave the node without an address
   end

   always @*
   begin
      rdata_nxt = setting_nxt;
      if (locked)
      begin
         rdata_nxt = switch_addr_r;
      end
   end

   // invalid switches leave the setting writable but are never adopted
   always @*
   begin
      invalid_nxt = !locked && !sw_zero;
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_r <= ST_SAMPLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         switch_addr_r <= 7'h00;
      end
      else
      begin
         switch_addr_r <= switch_addr_nxt;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         setting_r <= `FNAS_SETTING_RST;
      end
      else
      begin
         setting_r <= setting_nxt;
      end
   end

   // read value and flags keep their reset values until the sampled switches settle
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_setting_rdata <= `FNAS_SETTING_RST;
      end
      else if (running)
      begin
         o_setting_rdata <= rdata_nxt;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_station_addr <= 7'h00;
         o_addr_valid   <= 1'b0;
      end
      else if (running)
      begin
         o_station_addr <= station_nxt;
         o_addr_valid   <= valid_nxt;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_switch_locked  <= 1'b0;
         o_switch_invalid <= 1'b0;
         o_ready          <= 1'b0;
      end
      else if (running)
      begin
         o_switch_locked  <= locked;
         o_switch_invalid <= invalid_nxt;
         o_ready          <= 1'b1;
      end
   end

endmodule

/* hdl/fnas_range_check.v */
`timescale 1ns/1ns
`include "fnas_regs.vh"

// usable station address check
module fnas_range_check
(
   input  wire [6:0] i_addr,
   output wire       o_valid
);

   assign o_valid = (i_addr >= `FNAS_ADDR_MIN) && (i_addr <= `FNAS_ADDR_MAX);

endmodule

/* hdl/fnas_regs.vh */
`ifndef FNAS_REGS_VH
`define FNAS_REGS_VH

`define FNAS_ADDR_W        7
`define FNAS_ADDR_MIN      7'h01
`define FNAS_ADDR_MAX      7'h7d
`define FNAS_ADDR_SW_SEL   7'h00
`define FNAS_SETTING_RST   7'h03

`endif

/* verif/fnas_dip_bank.sv */
`timescale 1ns/1ns
// far-side switch bank, copies the chosen setting onto the pins
module fnas_dip_bank
(
   input  [6:0] i_set,
   output [6:0] o_sw
);
   assign o_sw = i_set;
endmodule

/* verif/fnas_properties.sv */
`timescale 1ns/1ns
module fnas_chk
(
   input       i_clk,
   input       i_reset,
   input [6:0] i_switch,
   input       i_setting_wr,
   input [6:0] i_setting_wdata,
   input [6:0] o_setting_rdata,
   input [6:0] o_station_addr,
   input       o_addr_valid,
   input       o_switch_locked,
   input       o_switch_invalid,
   input       o_ready
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   wire ok = i_setting_wdata inside {[7'h01:7'h7d]};
   wire sw = o_ready && !o_switch_locked;
   chk_lock_read: assert property (o_switch_locked |-> o_setting_rdata == o_station_addr)
      else $error("locked readback differs");
   chk_addr_range: assert property (o_addr_valid |-> o_station_addr inside {[1:125]})
      else $error("station address out of range");
   chk_bad_sw: assert property (o_switch_invalid |-> !o_addr_valid)
      else $error("invalid switches adopted");
   chk_sw_hold: assert property (o_switch_locked |=> $stable(o_station_addr))
      else $error("switch address moved");
   chk_wr_locked: assert property (o_switch_locked && i_setting_wr |=> $stable(o_setting_rdata))
      else $error("locked setting changed");
   chk_wr_reject: assert property (sw && i_setting_wr && !ok |=> $stable(o_setting_rdata))
      else $error("bad write taken");
   chk_wr_take: assert property (sw && i_setting_wr && ok |=> o_setting_rdata == $past(i_setting_wdata))
      else $error("good write lost");
   chk_soft_sel: assert property (sw && !o_switch_invalid |-> o_station_addr == o_setting_rdata)
      else $error("soft address not used");
   cover property (o_switch_locked && i_setting_wr);
   cover property (o_switch_invalid);
   cover property (sw && i_setting_wr && ok);
endmodule
bind fnas_node_address_select fnas_chk i_chk (.*);

/* verif/tb.sv */
`timescale 1ns/1ns
module tb;
   reg        clk = 0;
   reg        rst = 1;
   reg        wr = 0;
   reg  [6:0] sel = 0;
   reg  [6:0] wd = 0;
   wire [6:0] sw, rd, st;
   wire       v, lk, inv, rdy;
   integer    bad_count = 0;
   integer    n_checks = 0;
   integer    cyc = 0;
   always #20 clk = ~clk;
   fnas_dip_bank i_dip (.i_set(sel), .o_sw(sw));
   fnas_node_address_select i_dut (.i_clk(clk), .i_reset(rst), .i_switch(sw),
      .i_setting_wr(wr), .i_setting_wdata(wd), .o_setting_rdata(rd), .o_station_addr(st),
      .o_addr_valid(v), .o_switch_locked(lk), .o_switch_invalid(inv), .o_ready(rdy));
   task chk(input [6:0] g, input [6:0] e);
      n_checks = n_checks + 1;
      bad_count = bad_count + (g !== e);
      if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
   endtask
   task boot(input [6:0] s);
      sel = s;
      rst = 1;
      repeat (5) @(posedge clk);
      #1 rst = 0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task chk_bit(input g, input e);
      n_checks = n_checks + 1;
      bad_count = bad_count + (g !== e);
      if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
   endtask
   task put(input [6:0] d);
      wr = 1;
      wd = d;
      @(posedge clk);
      #1 wr = 0;
      @(posedge clk);
      #1;
   endtask
   task soft_addr;
      boot(7'h00);
      chk(rd, 7'h03);
      chk(st, 7'h03);
      chk_bit(v, 1'b1);
      chk_bit(lk, 1'b0);
      chk_bit(rdy, 1'b1);
      put(7'h10);
      chk(st, 7'h10);
      chk(rd, 7'h10);
      put(7'h7e);
      chk(rd, 7'h10);
      put(7'h00);
      chk(rd, 7'h10);
      chk(st, 7'h10);
   endtask
   task switch_addr;
      boot(7'h58);
      chk(st, 7'h58);
      chk_bit(lk, 1'b1);
      chk_bit(inv, 1'b0);
      put(7'h05);
      chk(rd, 7'h58);
      sel = 7'h11;
      repeat (2) @(posedge clk);
      #1 chk(st, 7'h58);
      chk(rd, 7'h58);
   endtask
   task switch_weights;
      integer i;
      for (i = 0; i < 7; i = i + 1)
      begin
         boot(7'h01 << i);
         chk(st, 7'h01 << i);
      end
   endtask
   task bad_switch;
      boot(7'h7f);
      chk_bit(v, 1'b0);
      chk_bit(inv, 1'b1);
      chk(st, 7'h00);
      boot(7'h7e);
      chk_bit(v, 1'b0);
      put(7'h21);
      chk(rd, 7'h21);
      chk(st, 7'h00);
   endtask
   task complete_run;
      if (bad_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      bad_count = bad_count + (cyc == 500);
      if (cyc == 500) complete_run;
   end
   initial
   begin
      soft_addr;
      switch_addr;
      switch_weights;
      bad_switch;
      complete_run;
   end
endmodule
